/* File: rtl/mii_phy_pkg.sv */
package mii_phy_pkg;

	// Core clock and bit times, in ns
	localparam int REF_CLK_NS = 40;
	localparam int BIT_NS_10  = 100;
	localparam int BIT_NS_100 = 10;

	// Half periods of the MII clocks in core cycles: 4 bits per nibble period
	localparam int MII_HALF_10 = (4 * BIT_NS_10 / 2) / REF_CLK_NS;
	// A flop-made clock cannot match its own source, so 100M runs at half rate
	localparam int MII_HALF_100 = 1;
	localparam int DIV_W = 3;
	localparam logic [DIV_W-1:0] DIV_RST = 3'h0;

	// Latency bounds in bit times, and largest cycle counts (round down) for the 10M receive and carrier-on bounds
	localparam int RX_LAT_10_BITS   = 7;
	localparam int TX_LAT_10_BITS   = 2;
	localparam int TX_LAT_100_BITS  = 3;
	localparam int CRS_ON_100_BITS  = 4;
	localparam int CRS_OFF_100_BITS = 4;
	localparam int CRS_ON_10_BITS   = 2;
	localparam int CRS_OFF_10_BITS  = 4;
	localparam int RX_LAT_10_CYC    = RX_LAT_10_BITS * BIT_NS_10 / REF_CLK_NS;
	localparam int CRS_ON_10_CYC    = CRS_ON_10_BITS * BIT_NS_10 / REF_CLK_NS;

	// Crossing buffer address width
	localparam int XF_AW = 2;

	// Nibble from the MAC
	typedef struct packed {
		logic [3:0] txd;
		logic       en;
		logic       er;
	} mii_tx_t;

	// Nibble toward the MAC, and nibble at the line
	typedef struct packed {
		logic [3:0] data;
		logic       dv;
		logic       er;
	} sym_t;

	localparam sym_t SYM_IDLE = '{data: 4'h0, dv: 1'b0, er: 1'b0};
	localparam sym_t SYM_UNDERRUN = '{data: 4'h0, dv: 1'b1, er: 1'b1};
	localparam mii_tx_t TX_IDLE_VAL = '{txd: 4'h0, en: 1'b0, er: 1'b0};
	localparam logic CRS_RST = 1'b0;
	localparam logic COL_RST = 1'b0;
	localparam logic MII_CLK_RST = 1'b0;

	typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_ACTIVE = 2'b10} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_FRAME = 2'b10} rx_state_t;

endpackage

/* File: rtl/mii_clk_div.sv */
`timescale 1ns/100ps
module mii_clk_div (
	input  wire logic clk_in,       // Core clock
	input  wire logic resetn_in,    // Async reset, active low
	input  wire logic speed_100_in, // Synchronised speed select
	output logic      level_out,    // MII clock level, registered
	output logic      tick_out      // Level flips at the coming edge
);
	logic [mii_phy_pkg::DIV_W-1:0] cnt_r;
	logic [mii_phy_pkg::DIV_W-1:0] last_w;

	// Terminal count for the selected speed
	assign last_w = speed_100_in ? mii_phy_pkg::DIV_W'(mii_phy_pkg::MII_HALF_100 - 1)
	                             : mii_phy_pkg::DIV_W'(mii_phy_pkg::MII_HALF_10 - 1);
	// A count above the new terminal after a speed change wraps at once
	assign tick_out = (cnt_r >= last_w);

	// Half-period counter
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_r <= mii_phy_pkg::DIV_RST;
		end else if (tick_out) begin
			cnt_r <= mii_phy_pkg::DIV_RST;
		end else begin
			cnt_r <= cnt_r + 3'h1;
		end
	end

	// Clock level
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			level_out <= mii_phy_pkg::MII_CLK_RST;
		end else if (tick_out) begin
			level_out <= ~level_out;
		end
	end
endmodule

/* File: rtl/line_rx_cross.sv */
`timescale 1ns/100ps
module line_rx_cross (
	input  wire logic              line_clk_in,  // Recovered line clock
	input  wire logic              resetn_in,    // Async reset, active low
	input  wire mii_phy_pkg::sym_t sym_in,       // Line nibble, line domain
	input  wire logic              rd_clk_in,    // Core clock
	input  wire logic              rd_en_in,     // Pop one nibble
	output mii_phy_pkg::sym_t      rd_data_out,  // Oldest nibble
	output logic                   empty_out     // Nothing waiting
);
	localparam int AW = mii_phy_pkg::XF_AW;

	mii_phy_pkg::sym_t mem [0:(1<<AW)-1];
	logic          lrst1_r;
	logic          lrst2_r;
	logic          last_dv_r;
	logic [AW:0]   wbin_r;
	logic [AW:0]   wgray_r;
	logic [AW:0]   rg_s1_r;
	logic [AW:0]   rg_s2_r;
	logic [AW:0]   rbin_r;
	logic [AW:0]   rgray_r;
	logic [AW:0]   wg_s1_r;
	logic [AW:0]   wg_s2_r;
	logic          full_w;
	logic          wr_w;
	logic [AW:0]   wbin_nxt;
	logic [AW:0]   rbin_nxt;

	function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction

	// Reset release for the line domain, so no line flop leaves reset mid-edge
	always_ff @(posedge line_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			lrst1_r <= 1'b0;
			lrst2_r <= 1'b0;
		end else begin
			lrst1_r <= 1'b1;
			lrst2_r <= lrst1_r;
		end
	end

	// One trailing idle nibble is kept so the far side sees the frame end
	assign full_w = (wgray_r == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
	assign wr_w = (sym_in.dv | last_dv_r) & ~full_w;
	assign wbin_nxt = wbin_r + {{AW{1'b0}}, 1'b1};

	// Write side; the line cannot stall, so a nibble is lost when full
	always_ff @(posedge line_clk_in or negedge lrst2_r) begin
		if (!lrst2_r) begin
			wbin_r <= '0;
			wgray_r <= '0;
			last_dv_r <= 1'b0;
			rg_s1_r <= '0;
			rg_s2_r <= '0;
		end else begin
			last_dv_r <= sym_in.dv;
			rg_s1_r <= rgray_r;
			rg_s2_r <= rg_s1_r;
			if (wr_w) begin
				wbin_r <= wbin_nxt;
				wgray_r <= bin2gray(wbin_nxt);
			end
		end
	end

	// Storage, written only in the line domain
	always_ff @(posedge line_clk_in) begin
		if (wr_w) begin
			mem[wbin_r[AW-1:0]] <= sym_in;
		end
	end

	assign empty_out = (rgray_r == wg_s2_r);
	assign rd_data_out = mem[rbin_r[AW-1:0]];
	assign rbin_nxt = rbin_r + {{AW{1'b0}}, 1'b1};

	// Read side; gray pointers change one bit at a time across the boundary
	always_ff @(posedge rd_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rbin_r <= '0;
			rgray_r <= '0;
			wg_s1_r <= '0;
			wg_s2_r <= '0;
		end else begin
			wg_s1_r <= wgray_r;
			wg_s2_r <= wg_s1_r;
			if (rd_en_in && !empty_out) begin
				rbin_r <= rbin_nxt;
				rgray_r <= bin2gray(rbin_nxt);
			end
		end
	end
endmodule

/* File: rtl/mii_phy_latency_carrier_timing.sv */
`timescale 1ns/100ps
module mii_phy_latency_carrier_timing (
	input  wire logic                 ref_clk_in,      // 25 MHz core clock
	input  wire logic                 resetn_in,       // Async reset, active low
	input  wire logic                 line_clk_in,     // Line receive clock
	input  wire mii_phy_pkg::sym_t    line_rx_in,      // Line receive pair nibble
	input  wire mii_phy_pkg::mii_tx_t tx_in,           // Nibble from the MAC
	input  wire logic                 speed_100_in,    // High for 100 Mb/s
	input  wire logic                 full_duplex_in,  // High for full duplex
	output logic                      tx_clk_out,      // MII transmit clock
	output logic                      rx_clk_out,      // MII receive clock
	output mii_phy_pkg::sym_t         rx_out,          // Nibble toward the MAC
	output logic                      crs_out,         // Carrier sense
	output logic                      col_out,         // Collision
	output mii_phy_pkg::sym_t         line_tx_out      // Line transmit pair nibble
);

	logic                   spd_s1_r;
	logic                   spd_s2_r;
	logic                   fdx_s1_r;
	logic                   fdx_s2_r;
	logic                   tick_w;
	logic                   tx_lvl_w;
	logic                   tx_rise_w;
	logic                   rx_fall_w;
	logic                   rx_clk_r;
	mii_phy_pkg::sym_t      line_tx_r;
	mii_phy_pkg::sym_t      line_tx_nxt;
	mii_phy_pkg::sym_t      xf_data_w;
	logic                   xf_empty_w;
	logic                   xf_pop_w;
	mii_phy_pkg::rx_state_t rx_state_r;
	mii_phy_pkg::rx_state_t rx_state_nxt;
	mii_phy_pkg::sym_t      rx_r;
	mii_phy_pkg::sym_t      rx_nxt;
	logic                   crs_r;
	logic                   crs_nxt;
	logic                   col_r;
	logic                   col_nxt;

	// Straps come from pins, so each passes two flops before use
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			spd_s1_r <= 1'b0;
			spd_s2_r <= 1'b0;
			fdx_s1_r <= 1'b0;
			fdx_s2_r <= 1'b0;
		end else begin
			spd_s1_r <= speed_100_in;
			spd_s2_r <= spd_s1_r;
			fdx_s1_r <= full_duplex_in;
			fdx_s2_r <= fdx_s1_r;
		end
	end

	// One divider paces both MII clocks; it sets the bit time per speed
	mii_clk_div u_div (
		.clk_in       (ref_clk_in),
		.resetn_in    (resetn_in),
		.speed_100_in (spd_s2_r),
		.level_out    (tx_lvl_w),
		.tick_out     (tick_w)
	);

	// Edge strobes: true in the cycle whose closing edge moves the clock
	assign tx_rise_w = tick_w & ~tx_lvl_w;
	assign rx_fall_w = tick_w & rx_clk_r;

	// Receive clock runs in step with the transmit clock
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_clk_r <= mii_phy_pkg::MII_CLK_RST;
		end else if (tick_w) begin
			rx_clk_r <= ~rx_clk_r;
		end
	end

	// The MAC drives its inputs from our transmit clock, so they are taken
	// here unsynchronised; the line nibble is formed from them at the edge
	// that raises the clock, so the first line bit adds no cycle, and an
	// error outside a frame is dropped
	always_comb begin
		line_tx_nxt = line_tx_r;
		if (tx_rise_w) begin
			line_tx_nxt.data = tx_in.en ? tx_in.txd : 4'h0;
			line_tx_nxt.dv = tx_in.en;
			line_tx_nxt.er = tx_in.en & tx_in.er;
		end
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			line_tx_r <= mii_phy_pkg::SYM_IDLE;
		end else begin
			line_tx_r <= line_tx_nxt;
		end
	end

	// Line receive nibbles cross into the core clock through gray pointers
	line_rx_cross u_xf (
		.line_clk_in (line_clk_in),
		.resetn_in   (resetn_in),
		.sym_in      (line_rx_in),
		.rd_clk_in   (ref_clk_in),
		.rd_en_in    (xf_pop_w),
		.rd_data_out (xf_data_w),
		.empty_out   (xf_empty_w)
	);

	// One nibble is taken per receive clock period, at its falling edge
	assign xf_pop_w = rx_fall_w & ~xf_empty_w;

	// Receive presentation; a gap inside a frame is flagged as an error
	// rather than closing the frame, since the MAC cannot tell otherwise
	always_comb begin
		rx_state_nxt = rx_state_r;
		rx_nxt = rx_r;
		if (rx_fall_w) begin
			case (rx_state_r)
				mii_phy_pkg::RX_IDLE: begin
					rx_nxt = mii_phy_pkg::SYM_IDLE;
					if (!xf_empty_w && xf_data_w.dv) begin
						rx_nxt = xf_data_w;
						rx_state_nxt = mii_phy_pkg::RX_FRAME;
					end
				end
				mii_phy_pkg::RX_FRAME: begin
					if (xf_empty_w) begin
						rx_nxt = mii_phy_pkg::SYM_UNDERRUN;
					end else if (!xf_data_w.dv) begin
						rx_nxt = mii_phy_pkg::SYM_IDLE;
						rx_state_nxt = mii_phy_pkg::RX_IDLE;
					end else begin
						rx_nxt = xf_data_w;
					end
				end
				default: begin
					rx_nxt = mii_phy_pkg::SYM_IDLE;
					rx_state_nxt = mii_phy_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// Outputs change only at the falling edge, half a period from sampling
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_state_r <= mii_phy_pkg::RX_IDLE;
			rx_r <= mii_phy_pkg::SYM_IDLE;
		end else begin
			rx_state_r <= rx_state_nxt;
			rx_r <= rx_nxt;
		end
	end

	// Carrier follows the live enable every core cycle: waiting for the
	// sampling edge would cost a whole 10M clock period, beyond the two
	// bit bound; full duplex shows receive activity only
	always_comb begin
		crs_nxt = (~fdx_s2_r & tx_in.en) | rx_r.dv;
		col_nxt = ~fdx_s2_r & tx_in.en & rx_r.dv;
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			crs_r <= mii_phy_pkg::CRS_RST;
			col_r <= mii_phy_pkg::COL_RST;
		end else begin
			crs_r <= crs_nxt;
			col_r <= col_nxt;
		end
	end

	// Every output leaves straight from a flop
	assign tx_clk_out = tx_lvl_w;
	assign rx_clk_out = rx_clk_r;
	assign rx_out = rx_r;
	assign crs_out = crs_r;
	assign col_out = col_r;
	assign line_tx_out = line_tx_r;

endmodule

/* File: testbench/mii_mac_model.sv */
`timescale 1ns/100ps
module mii_mac_model (
	input  wire logic           ref_clk_in, // Core clock
	input  wire logic           resetn_in,  // Reset, active low
	input  wire logic           tx_clk_in,  // Transmit clock from the PHY
	input  wire logic [1:0]     mode_in,    // 0 idle, 1 frame, 2 stray error
	output mii_phy_pkg::mii_tx_t tx_out     // Nibble to the PHY
);
	logic tck_r; // Clock level at the last edge
	// Change one cycle after a rise, so each nibble stands across the next rise
	// One nibble per clock period at either rate
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tck_r  <= 1'b0;
			tx_out <= mii_phy_pkg::TX_IDLE_VAL;
		end else begin
			tck_r <= tx_clk_in;
			if (tx_clk_in && !tck_r) begin
				tx_out.txd <= 4'($urandom);
				tx_out.en  <= (mode_in == 2'h1);
				tx_out.er  <= (mode_in == 2'h2) || (mode_in == 2'h1 && $urandom_range(7) == 0);
			end
		end
	end
endmodule

/* File: testbench/mii_phy_sva.sv */
`timescale 1ns/100ps
module mii_phy_sva (
	input wire logic                 ref_clk_in,     // Core clock
	input wire logic                 resetn_in,      // Reset, active low
	input wire logic                 line_clk_in,    // Line clock
	input wire mii_phy_pkg::sym_t    line_rx_in,     // Line nibble in
	input wire mii_phy_pkg::mii_tx_t tx_in,          // MAC nibble
	input wire logic                 speed_100_in,   // Speed strap
	input wire logic                 full_duplex_in, // Duplex strap
	input wire logic                 tx_clk_out,     // Transmit clock
	input wire logic                 rx_clk_out,     // Receive clock
	input wire mii_phy_pkg::sym_t    rx_out,         // Nibble to MAC
	input wire logic                 crs_out,        // Carrier
	input wire logic                 col_out,        // Collision
	input wire mii_phy_pkg::sym_t    line_tx_out     // Line nibble out
);
	logic [2:0] up_r; // Cycles since reset, saturating
	// Straps need a few cycles through their synchroniser before clock shape is fixed
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) up_r <= 3'h0;
		else if (up_r != 3'h7) up_r <= up_r + 3'h1;
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	sequence hi_five;
		tx_clk_out [*5] ##1 !tx_clk_out;
	endsequence
	sequence lo_hi;
		!tx_clk_out ##1 tx_clk_out;
	endsequence
	tx_capture_a: assert property ($rose(tx_clk_out) |->
		line_tx_out.dv == $past(tx_in.en) && line_tx_out.er == ($past(tx_in.er) && $past(tx_in.en))
		&& line_tx_out.data == ($past(tx_in.en) ? $past(tx_in.txd) : 4'h0))
		else $error("line nibble differs from sampled MAC nibble");
	line_hold_a: assert property (!$rose(tx_clk_out) |-> $stable(line_tx_out))
		else $error("line nibble moved between clock rises");
	rx_hold_a: assert property (!$fell(rx_clk_out) |-> $stable(rx_out))
		else $error("receive nibble moved near a clock rise");
	clk_pair_a: assert property (tx_clk_out == rx_clk_out)
		else $error("receive clock out of phase with transmit clock");
	crs_on_a: assert property ($rose(tx_clk_out) && line_tx_out.dv && !full_duplex_in |-> crs_out)
		else $error("carrier late after enable");
	crs_off_a: assert property ($rose(tx_clk_out) && !line_tx_out.dv && !rx_out.dv |-> !crs_out)
		else $error("carrier late to drop");
	col_gate_a: assert property (col_out |-> crs_out && !full_duplex_in)
		else $error("collision without carrier or in full duplex");
	crs_track_a: assert property (!full_duplex_in && tx_in.en || rx_out.dv |=> crs_out)
		else $error("carrier missing while enabled or receiving");
	crs_clear_a: assert property (!tx_in.en && !rx_out.dv |=> !crs_out)
		else $error("carrier held without enable or receive");
	col_set_a: assert property (!full_duplex_in && tx_in.en && rx_out.dv |=> col_out)
		else $error("collision missing during overlap");
	slow_clk_a: assert property (up_r == 3'h7 && !speed_100_in && $rose(tx_clk_out) |-> hi_five)
		else $error("slow clock high phase not five cycles");
	fast_clk_a: assert property (up_r == 3'h7 && speed_100_in && $rose(tx_clk_out) |=> lo_hi)
		else $error("fast clock period not two cycles");
endmodule
bind mii_phy_latency_carrier_timing mii_phy_sva mii_phy_sva_i (.ref_clk_in, .resetn_in,
	.line_clk_in, .line_rx_in, .tx_in, .speed_100_in, .full_duplex_in, .tx_clk_out,
	.rx_clk_out, .rx_out, .crs_out, .col_out, .line_tx_out);

/* File: testbench/tb.sv */
`timescale 1ns/100ps
module tb;
	logic                 ref_clk_in, resetn_in, line_clk_in, speed_100_in, full_duplex_in;
	logic                 tx_clk_out, rx_clk_out, crs_out, col_out, prev_tck, prev_rck, first;
	logic [1:0]           mode;
	mii_phy_pkg::sym_t    line_rx_in, rx_out, line_tx_out;
	mii_phy_pkg::mii_tx_t tx_in, prev_tx;
	mii_phy_pkg::sym_t    rxq[$];
	int                   failures, n_checks, cyc;
	realtime              t0;

	mii_phy_latency_carrier_timing mii_phy_latency_carrier_timing_i (.ref_clk_in, .resetn_in,
		.line_clk_in, .line_rx_in, .tx_in, .speed_100_in, .full_duplex_in, .tx_clk_out,
		.rx_clk_out, .rx_out, .crs_out, .col_out, .line_tx_out);
	mii_mac_model mii_mac_model_i (.ref_clk_in, .resetn_in, .tx_clk_in(tx_clk_out),
		.mode_in(mode), .tx_out(tx_in));

	// 25 MHz core clock
	initial begin
		ref_clk_in = 1'b0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end

	task chk_sym(input mii_phy_pkg::sym_t got, input mii_phy_pkg::sym_t exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t nibble %h expected %h", $time, got, exp);
		end
	endtask

	task chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task results;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Line clock runs only inside a frame and for two pulses in reset; three valid nibbles fit the crossing whole
	task line_frame(input int n);
		mii_phy_pkg::sym_t s;
		first = 1'b1;
		#7;
		for (int i = 0; i < n + 6; i++) begin
			#24 line_clk_in = 1'b1;
			s = '{4'($urandom), (i >= 2 && i < n + 2), 1'b0};
			if (s.dv) rxq.push_back(s);
			if (i == 3) t0 = $realtime;
			line_rx_in <= s;
			#24 line_clk_in = 1'b0;
		end
	endtask

	// Reference model: judge each transmit rise and each receive fall with rx_out.dv high once outputs settle
	always @(posedge ref_clk_in) begin
		prev_tx = tx_in;
		prev_tck = tx_clk_out;
		prev_rck = rx_clk_out;
		#1;
		if (resetn_in && !prev_tck && tx_clk_out) begin
			chk_sym(line_tx_out, '{prev_tx.en ? prev_tx.txd : 4'h0, prev_tx.en, prev_tx.en & prev_tx.er});
			chk_bit(crs_out, (!full_duplex_in & prev_tx.en) | rx_out.dv);
			chk_bit(col_out, !full_duplex_in & prev_tx.en & rx_out.dv);
		end
		if (resetn_in && prev_rck && !rx_clk_out && rx_out.dv) begin
			if (first && !speed_100_in)
				chk_bit(($realtime - t0) <= mii_phy_pkg::RX_LAT_10_BITS * mii_phy_pkg::BIT_NS_10, 1'b1);
			first = 1'b0;
			chk_sym(rx_out, rxq.size() > 0 ? rxq.pop_front() : mii_phy_pkg::SYM_IDLE);
		end
	end

	// Hang guard, well above the roughly 1600 cycles the run needs
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 8000) begin
			failures++;
			$display("[ERR] %0t run did not finish", $time);
			results();
		end
	end

	// Every speed and duplex pair: stray errors, transmit with overlapping receive, lone receive
	initial begin
		resetn_in = 1'b0;
		line_clk_in = 1'b0;
		line_rx_in = mii_phy_pkg::SYM_IDLE;
		mode = 2'h0;
		speed_100_in = 1'b0;
		full_duplex_in = 1'b0;
		failures = 0;
		n_checks = 0;
		cyc = 0;
		first = 1'b0;
		void'($urandom(347));
		for (int cfg = 0; cfg < 4; cfg++) begin
			@(posedge ref_clk_in);
			resetn_in <= 1'b0;
			speed_100_in <= cfg[0];
			full_duplex_in <= cfg[1];
			repeat (2) begin
				#24 line_clk_in = 1'b1;
				#24 line_clk_in = 1'b0;
			end
			repeat (3) @(posedge ref_clk_in);
			chk_sym(line_tx_out, mii_phy_pkg::SYM_IDLE);
			chk_bit(crs_out, mii_phy_pkg::CRS_RST);
			resetn_in <= 1'b1;
			repeat (8) @(posedge ref_clk_in);
			mode <= 2'h2;
			repeat (40) @(posedge ref_clk_in);
			mode <= 2'h1;
			fork
				line_frame(3);
				repeat (200) @(posedge ref_clk_in);
			join
			mode <= 2'h0;
			repeat (60) @(posedge ref_clk_in);
			line_frame(3);
			repeat (80) @(posedge ref_clk_in);
			chk_bit(rxq.size() == 0, 1'b1);
		end
		results();
	end
endmodule
